// ### inc/pcl_pkg.sv
// Package with constants and carrier types of the peripheral clock control block
package pcl_pkg;

    // ------------------------------------------------------------------
    // Core clock and low-speed oscillator timing
    // ------------------------------------------------------------------
    localparam int CORE_CLK_KHZ = 250000;
    localparam int LS_OSC_FREQ_KHZ = 240;
    // Full period rounds down so the emulated oscillator is never slower than typical
    localparam int LS_OSC_PERIOD_CYCLES = CORE_CLK_KHZ / LS_OSC_FREQ_KHZ;
    localparam int LS_CNT_WIDTH = 11;

    // ------------------------------------------------------------------
    // Peripheral clock divider field encoding
    // ------------------------------------------------------------------
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_2 = 2'h1;
    localparam logic [1:0] DIV_BY_4 = 2'h2;
    localparam logic [1:0] DIV_PROHIBITED = 2'h3;
    localparam logic [1:0] DIV_RESET = DIV_BY_1;
    localparam logic [1:0] DIV_CNT_ZERO = 2'h0;
    localparam logic [1:0] DIV_CNT_ONE = 2'h1;
    localparam logic [1:0] DIV_CNT_THREE = 2'h3;

    // ------------------------------------------------------------------
    // Low-speed oscillator mode register reset value
    // ------------------------------------------------------------------
    localparam logic LS_STOP_RESET = 1'h0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PCL_WDT_SRC_STOP,
        PCL_WDT_SRC_PERIPH,
        PCL_WDT_SRC_LOWSPEED,
        PCL_WDT_SRC_SPARE
    } pcl_wdt_src_type;

    typedef struct packed {
        logic [1:0] peripheral_clock_divider_reg;
        logic lowspeed_osc_stop_bit;
        pcl_wdt_src_type wdt_src;
        logic timer_uses_lowspeed;
    } pcl_ctl_type;

    typedef struct packed {
        logic periph_clk_en;
        logic lowspeed_clk_en;
        logic watchdog_clk_en;
        logic timer_clk_en;
    } pcl_clk_type;

    typedef struct packed {
        logic [1:0] active_divider;
        logic lowspeed_running;
        logic stop_permitted;
        pcl_wdt_src_type wdt_src_effective;
    } pcl_status_type;

endpackage : pcl_pkg

// ### design/pcl_lowspeed_osc.sv
// Low-speed oscillator model: enable pulse at the oscillator rate while running
`timescale 1ns/100ps
module pcl_lowspeed_osc #(
    parameter int PERIOD_CYCLES = pcl_pkg::LS_OSC_PERIOD_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    output logic tick
);
    import pcl_pkg::*;

    localparam logic [LS_CNT_WIDTH-1:0] LAST = LS_CNT_WIDTH'(PERIOD_CYCLES - 1);
    localparam logic [LS_CNT_WIDTH-1:0] CNT_ZERO = '0;

    logic [LS_CNT_WIDTH-1:0] phase;

    // ------------------------------------------------------------------
    // Free-running phase, held at zero while stopped so a restart is clean
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst || !run) begin
            phase <= CNT_ZERO;
        end else if (phase == LAST) begin
            phase <= CNT_ZERO;
        end else begin
            phase <= phase + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= run && (phase == LAST);
        end
    end

endmodule : pcl_lowspeed_osc

// ### design/pcl_clock_ctl.sv
// Peripheral clock divider and low-speed oscillator control
//
// Overview of operation
// - The peripheral clock is the system clock of the selected oscillator, divided.
// - Peripherals get two clocks: the divided peripheral clock and the low-speed clock.
// - A two-bit field of the divider control register chooses the peripheral clock ratio.
// - Field 00 passes the system clock, 01 halves it, 10 divides by four, 11 is never written.
// - The low-speed oscillator starts by itself when reset is released, at about 240 kHz.
// - An option byte setting decides whether software may stop the low-speed oscillator.
// - When stopping is permitted, the oscillator mode register starts or stops the oscillator.
// - When stopping is not permitted, the watchdog is clocked from the low-speed oscillator.
// - The low-speed oscillator runs independently of the processor clock.
// - A timer counting the low-speed clock keeps counting during standby.
// - Stop bit 1 halts watchdog and timer; stop bit 0 runs both, but in standby only the timer.
// - With stopping not permitted, the watchdog runs in operation and in standby.
// - The watchdog clock is the peripheral clock, the low-speed clock, or stopped.
`timescale 1ns/100ps
module pcl_clock_ctl #(
    parameter int LS_PERIOD_CYCLES = pcl_pkg::LS_OSC_PERIOD_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic system_clock_en,
    input wire logic option_stop_permit,
    input wire logic cpu_standby,
    input wire logic cpu_clock_stopped,
    input wire pcl_pkg::pcl_ctl_type ctl,
    output pcl_pkg::pcl_clk_type clk_out,
    output pcl_pkg::pcl_status_type status
);
    import pcl_pkg::*;

    // ------------------------------------------------------------------
    // Option byte capture
    // ------------------------------------------------------------------
    logic stop_permitted;
    logic option_loaded;

    // The option byte is read once after reset release and then held
    always_ff @(posedge core_clk) begin
        if (rst) begin
            option_loaded <= 1'b0;
        end else begin
            option_loaded <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stop_permitted <= 1'b0;
        end else if (!option_loaded) begin
            stop_permitted <= option_stop_permit;
        end
    end

    // ------------------------------------------------------------------
    // Peripheral clock divider
    // ------------------------------------------------------------------
    logic [1:0] active_divider;
    logic [1:0] div_cnt;
    logic [1:0] div_last;
    logic period_end;
    logic [1:0] next_divider;

    always_comb begin
        case (active_divider)
            DIV_BY_1: div_last = DIV_CNT_ZERO;
            DIV_BY_2: div_last = DIV_CNT_ONE;
            DIV_BY_4: div_last = DIV_CNT_THREE;
            default: div_last = DIV_CNT_ZERO;
        endcase
    end

    // A period ends on the last enabled system cycle of the ratio in force
    assign period_end = system_clock_en && (div_cnt == div_last);

    // Prohibited code keeps the ratio already in use
    always_comb begin
        if (ctl.peripheral_clock_divider_reg == DIV_PROHIBITED) begin
            next_divider = active_divider;
        end else begin
            next_divider = ctl.peripheral_clock_divider_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_cnt <= DIV_CNT_ZERO;
        end else if (period_end) begin
            div_cnt <= DIV_CNT_ZERO;
        end else if (system_clock_en) begin
            div_cnt <= div_cnt + DIV_CNT_ONE;
        end
    end

    // New ratio is taken only at the end of a full output period
    always_ff @(posedge core_clk) begin
        if (rst) begin
            active_divider <= DIV_RESET;
        end else if (period_end) begin
            active_divider <= next_divider;
        end
    end

    // ------------------------------------------------------------------
    // Low-speed oscillator run control
    // ------------------------------------------------------------------
    logic lowspeed_run;
    logic lowspeed_tick;

    // Runs from reset release; the processor clock state has no say here
    always_comb begin
        if (stop_permitted) begin
            lowspeed_run = !ctl.lowspeed_osc_stop_bit;
        end else begin
            lowspeed_run = 1'b1;
        end
    end

    // Phase restarts on each start, so the first tick comes a full period later
    pcl_lowspeed_osc #(
        .PERIOD_CYCLES(LS_PERIOD_CYCLES)
    ) u_lowspeed_osc (
        .core_clk(core_clk),
        .rst(rst),
        .run(lowspeed_run),
        .tick(lowspeed_tick)
    );

    // ------------------------------------------------------------------
    // Watchdog source selection
    // ------------------------------------------------------------------
    pcl_wdt_src_type wdt_src_eff;
    logic wdt_en;

    // The option byte lock overrides any software source choice
    always_comb begin
        if (!stop_permitted) begin
            wdt_src_eff = PCL_WDT_SRC_LOWSPEED;
        end else begin
            wdt_src_eff = ctl.wdt_src;
        end
    end

    always_comb begin
        case (wdt_src_eff)
            PCL_WDT_SRC_PERIPH: wdt_en = period_end && !cpu_clock_stopped;
            PCL_WDT_SRC_LOWSPEED: begin
                if (!stop_permitted) begin
                    wdt_en = lowspeed_tick;
                end else begin
                    wdt_en = lowspeed_tick && !cpu_standby;
                end
            end
            PCL_WDT_SRC_STOP: wdt_en = 1'b0;
            // The spare code behaves as a stopped source
            default: wdt_en = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Output clock enables
    // ------------------------------------------------------------------
    logic periph_pulse;
    logic lowspeed_pulse;
    logic watchdog_pulse;
    logic timer_pulse;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            periph_pulse <= 1'b0;
            lowspeed_pulse <= 1'b0;
        end else begin
            periph_pulse <= period_end;
            lowspeed_pulse <= lowspeed_tick;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            watchdog_pulse <= 1'b0;
        end else begin
            watchdog_pulse <= wdt_en;
        end
    end

    // Timer on the low-speed clock ignores standby; stop bit already gates the tick
    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_pulse <= 1'b0;
        end else if (ctl.timer_uses_lowspeed) begin
            timer_pulse <= lowspeed_tick;
        end else begin
            timer_pulse <= period_end && !cpu_standby;
        end
    end

    // Peripheral and low-speed enables share a process, watchdog and timer each have one; the struct is assembled once so it has one driver
    assign clk_out = '{periph_clk_en: periph_pulse,
                       lowspeed_clk_en: lowspeed_pulse,
                       watchdog_clk_en: watchdog_pulse,
                       timer_clk_en: timer_pulse};

    // ------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------
    // Status mirrors the internal state one cycle late
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status.active_divider <= DIV_RESET;
            status.lowspeed_running <= 1'b0;
            status.stop_permitted <= 1'b0;
            status.wdt_src_effective <= PCL_WDT_SRC_LOWSPEED;
        end else begin
            status.active_divider <= active_divider;
            status.lowspeed_running <= lowspeed_run;
            status.stop_permitted <= stop_permitted;
            status.wdt_src_effective <= wdt_src_eff;
        end
    end

endmodule : pcl_clock_ctl

// ### verif/pcl_clock_ctl_chk.sv
// Assertion checker for the peripheral clock control block
`timescale 1ns/100ps
module pcl_clock_ctl_chk #(
    parameter int LS_PERIOD_CYCLES = pcl_pkg::LS_OSC_PERIOD_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic system_clock_en,
    input wire logic option_stop_permit,
    input wire logic cpu_standby,
    input wire logic cpu_clock_stopped,
    input wire pcl_pkg::pcl_ctl_type ctl,
    input wire pcl_pkg::pcl_clk_type clk_out,
    input wire pcl_pkg::pcl_status_type status
);
    import pcl_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // Cycles since the last low-speed tick
    // ------------------------------------------------------------------
    int gap;
    logic gap_ok;
    always_ff @(posedge core_clk) begin
        if (rst || !status.lowspeed_running) begin
            gap <= 0;
            gap_ok <= 1'b0;
        end else if (clk_out.lowspeed_clk_en) begin
            gap <= 0;
            gap_ok <= 1'b1;
        end else begin
            gap <= gap + 1;
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_ls_period: assert property (clk_out.lowspeed_clk_en && gap_ok
        |-> gap == LS_PERIOD_CYCLES - 1) else $error("low-speed tick period wrong");
    a_div_two: assert property (clk_out.periph_clk_en ##1 status.active_divider == DIV_BY_2
        |-> !clk_out.periph_clk_en) else $error("divide by two pulse too close");
    a_div_four: assert property (clk_out.periph_clk_en ##1 status.active_divider == DIV_BY_4
        |-> !clk_out.periph_clk_en [*3]) else $error("divide by four pulse too close");
    a_no_prohib: assert property (status.active_divider != DIV_PROHIBITED)
        else $error("prohibited ratio applied");
    a_stop_halts: assert property (status.stop_permitted && ctl.lowspeed_osc_stop_bit
        |=> !status.lowspeed_running) else $error("oscillator did not stop");
    a_stop_quiet: assert property ((!status.lowspeed_running) [*2]
        |-> !clk_out.lowspeed_clk_en) else $error("tick while oscillator stopped");
    a_locked_src: assert property (!status.stop_permitted
        |-> status.wdt_src_effective == PCL_WDT_SRC_LOWSPEED)
        else $error("watchdog source not forced");
    a_locked_wdt: assert property ((!option_stop_permit && !status.stop_permitted) [*2]
        |-> clk_out.watchdog_clk_en == clk_out.lowspeed_clk_en)
        else $error("watchdog not on low-speed");
    a_wdt_off: assert property ((status.stop_permitted && ctl.wdt_src == PCL_WDT_SRC_STOP) [*2]
        |-> !clk_out.watchdog_clk_en) else $error("stopped watchdog clock ran");
    a_standby_wdt: assert property ((status.stop_permitted && cpu_standby
        && ctl.wdt_src == PCL_WDT_SRC_LOWSPEED) [*2] |-> !clk_out.watchdog_clk_en)
        else $error("watchdog ran in standby");
    a_timer_ls: assert property (ctl.timer_uses_lowspeed [*2]
        |-> clk_out.timer_clk_en == clk_out.lowspeed_clk_en) else $error("timer not on low-speed");
endmodule : pcl_clock_ctl_chk

bind pcl_clock_ctl pcl_clock_ctl_chk #(.LS_PERIOD_CYCLES(LS_PERIOD_CYCLES))
    pcl_clock_ctl_chk_inst (
    .core_clk(core_clk), .rst(rst), .system_clock_en(system_clock_en),
    .option_stop_permit(option_stop_permit), .cpu_standby(cpu_standby),
    .cpu_clock_stopped(cpu_clock_stopped), .ctl(ctl), .clk_out(clk_out), .status(status));

// ### verif/pcl_clock_ctl_tb_top.sv
// Self-checking bench of the peripheral clock control block
`timescale 1ns/100ps
module pcl_clock_ctl_tb_top;
    import pcl_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic system_clock_en = 1'b1;
    logic option_stop_permit = 1'b0;
    logic cpu_standby = 1'b0;
    logic cpu_clock_stopped = 1'b0;
    pcl_ctl_type ctl = '0;
    pcl_clk_type clk_out;
    pcl_status_type status;
    int mismatches = 0;
    int checked = 0;
    logic [7:0] n_per, n_ls, n_wd, n_tm;
    always #2 core_clk = ~core_clk;
    pcl_clock_ctl #(.LS_PERIOD_CYCLES(8)) pcl_clock_ctl_inst (.core_clk(core_clk), .rst(rst),
        .system_clock_en(system_clock_en), .option_stop_permit(option_stop_permit),
        .cpu_standby(cpu_standby), .cpu_clock_stopped(cpu_clock_stopped), .ctl(ctl),
        .clk_out(clk_out), .status(status));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic do_reset(input logic permit);
        @(negedge core_clk);
        rst = 1'b1;
        option_stop_permit = permit;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
    endtask : do_reset
    // Settles, then counts each enable over 64 cycles
    task automatic tally;
        repeat (16) @(negedge core_clk);
        {n_per, n_ls, n_wd, n_tm} = '0;
        repeat (64) begin
            @(negedge core_clk);
            n_per += 8'(clk_out.periph_clk_en);
            n_ls += 8'(clk_out.lowspeed_clk_en);
            n_wd += 8'(clk_out.watchdog_clk_en);
            n_tm += 8'(clk_out.timer_clk_en);
        end
    endtask : tally
    task automatic test_divider;
        for (int i = 0; i < 3; i++) begin
            ctl.peripheral_clock_divider_reg = 2'(i);
            tally();
            check(n_per, 8'h40 >> i);
            check({6'h0, status.active_divider}, 8'(i));
        end
        ctl.peripheral_clock_divider_reg = DIV_PROHIBITED;
        tally();
        check(n_per, 8'h10);
        ctl.peripheral_clock_divider_reg = DIV_BY_1;
        system_clock_en = 1'b0;
        tally();
        check(n_per, 8'h00);
        system_clock_en = 1'b1;
        $display("test_divider done");
    endtask : test_divider
    task automatic test_locked;
        ctl.lowspeed_osc_stop_bit = 1'b1;
        ctl.wdt_src = PCL_WDT_SRC_PERIPH;
        ctl.timer_uses_lowspeed = 1'b1;
        cpu_standby = 1'b1;
        tally();
        check(n_ls, 8'h08);
        check(n_wd, 8'h08);
        check(n_tm, 8'h08);
        check({6'h0, status.wdt_src_effective}, 8'(PCL_WDT_SRC_LOWSPEED));
        check({7'h0, status.stop_permitted}, 8'h00);
        $display("test_locked done");
    endtask : test_locked
    task automatic test_permit;
        ctl.lowspeed_osc_stop_bit = 1'b0;
        ctl.wdt_src = PCL_WDT_SRC_LOWSPEED;
        cpu_standby = 1'b0;
        do_reset(1'b1);
        tally();
        check(n_wd, 8'h08);
        check({7'h0, status.stop_permitted}, 8'h01);
        cpu_standby = 1'b1;
        tally();
        check(n_wd, 8'h00);
        check(n_tm, 8'h08);
        ctl.lowspeed_osc_stop_bit = 1'b1;
        tally();
        check(n_ls, 8'h00);
        check(n_wd, 8'h00);
        check(n_tm, 8'h00);
        check({7'h0, status.lowspeed_running}, 8'h00);
        ctl.lowspeed_osc_stop_bit = 1'b0;
        ctl.wdt_src = PCL_WDT_SRC_PERIPH;
        tally();
        check(n_wd, 8'h40);
        check(n_ls, 8'h08);
        cpu_clock_stopped = 1'b1;
        tally();
        check(n_wd, 8'h00);
        check(n_ls, 8'h08);
        ctl.wdt_src = PCL_WDT_SRC_STOP;
        cpu_clock_stopped = 1'b0;
        ctl.timer_uses_lowspeed = 1'b0;
        cpu_standby = 1'b0;
        tally();
        check(n_wd, 8'h00);
        check(n_tm, 8'h40);
        $display("test_permit done");
    endtask : test_permit
    task automatic give_verdict;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        do_reset(1'b0);
        test_divider();
        test_locked();
        test_permit();
        give_verdict();
    end
    initial begin
        #40000;
        mismatches++;
        give_verdict();
    end
endmodule : pcl_clock_ctl_tb_top
